// File: core/status_err_pkg.sv
// Constants shared by the status and error logging block
package status_err_pkg;

  // ********************************************************
  // Register byte offsets in configuration space
  // ********************************************************
  localparam logic [11:0] STATUS_OFFSET     = 12'h006;
  localparam logic [11:0] SEC_STATUS_OFFSET = 12'h01e;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int INTR_STATUS_BIT = 3;
  localparam int CAP_LIST_BIT    = 4;
  localparam int PARITY_ERR_BIT  = 8;
  localparam int SIG_ABORT_BIT   = 11;
  localparam int RCV_ABORT_BIT   = 12;
  localparam int RCV_UR_BIT      = 13;
  localparam int SYS_ERR_BIT     = 14;
  localparam int DET_PARITY_BIT  = 15;
  localparam int CMD_PER_BIT     = 6;
  localparam int CMD_SERR_BIT    = 8;
  localparam int HALF_WORD_LSB   = 16;

  // ********************************************************
  // Reset values and write-one-to-clear masks
  // ********************************************************
  localparam logic [15:0] STATUS_RESET     = 16'h0000;
  localparam logic [15:0] SEC_STATUS_RESET = 16'h0000;
  localparam logic        INTR_RESET       = 1'b0;
  localparam logic [15:0] STATUS_W1C_MASK  = 16'hf900;
  localparam logic [15:0] SEC_W1C_MASK     = 16'hf900;

  // ********************************************************
  // Configuration port handshake states
  // ********************************************************
  typedef enum logic [1:0] {
    PORT_IDLE = 2'b00,
    PORT_ACK  = 2'b01,
    PORT_WAIT = 2'b10
  } port_state_e;

endpackage

// File: core/w1c_bit_bank.sv
// Bank of sticky bits, set by hardware and cleared by writing one
`timescale 1ns/1ps
module w1c_bit_bank
  import status_err_pkg::*;
#(
  parameter int          WIDTH     = 16,
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             rst_b_in,
  // Set and clear strobes, one per bit
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  // Stored bits
  output logic      [WIDTH-1:0] bits_out
);

  // Refused while the design is built, before any clock runs
  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("w1c_bit_bank: WIDTH must be 1 to 16");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // A set in the same cycle as a clear wins, so no event is lost
      always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
          bits_out[i] <= RESET_VAL[i];
        end else if (set_in[i]) begin
          bits_out[i] <= 1'b1;
        end else if (clr_in[i]) begin
          bits_out[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// File: core/status_err_log.sv
// Status and secondary status error logging for a link port core
// What this block does
// - Reserved status bits read zero; capabilities-list bit always reads one.
// - Endpoint: interrupt status sets on user interrupt, clears when handler clears.
// - Endpoint: parity bit sets on poisoned completion received or poisoned write sent when enabled.
// - Endpoint: signaled abort bit sets when user reports a completer-abort completion.
// - Endpoint: received abort bit sets on completion with completer-abort status.
// - Endpoint: received master abort sets on completion with unsupported-request status.
// - Endpoint: system error bit sets on sent error message when enabled.
// - Endpoint: detected parity bit sets on any poisoned packet received.
// - Root port: interrupt status bit does nothing and stays zero.
// - Root port: parity bit sets on poisoned completion received when enabled.
// - Root port: status bits 11, 12 and 13 are never set.
// - Root port: system error sets on received error message with both enables.
// - Root port: system error sets on upstream error message indication when enabled.
// - Root port: detected parity bit sets on poisoned packet sent downstream.
// - Root port: secondary parity bit sets on poisoned completion or write when enabled.
// - Root port: secondary signaled abort sets on the user abort report input.
// - Root port: secondary received abort sets on completer-abort completion.
// - Root port: secondary master abort sets on unsupported-request completion.
// - Root port: secondary system error sets on any received error message.
// - Parity error response enable is command bit 6.
// - System error report enable is command bit 8.
`timescale 1ns/1ps
module status_err_log
  import status_err_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  // Static configuration
  input  wire logic        root_port_mode_in,
  // Command and bridge control settings
  input  wire logic [15:0] command_word_in,
  input  wire logic        secondary_parity_resp_en_in,
  input  wire logic        secondary_system_error_report_enable_in,
  // Link receive events, one-cycle pulses
  input  wire logic        rx_poisoned_cpl_in,
  input  wire logic        rx_poisoned_tlp_in,
  input  wire logic        rx_cpl_abort_in,
  input  wire logic        rx_cpl_unsupported_in,
  input  wire logic        rx_err_msg_in,
  // Link transmit events, one-cycle pulses
  input  wire logic        tx_poisoned_wr_in,
  input  wire logic        tx_poisoned_tlp_in,
  input  wire logic        tx_err_msg_in,
  input  wire logic        msg_upstream_err_in,
  // User application reports
  input  wire logic        user_cpl_abort_b_in,
  input  wire logic        intx_set_in,
  input  wire logic        intx_clear_in,
  // Configuration port
  input  wire logic [9:0]  cfg_dwaddr_in,
  input  wire logic [31:0] cfg_di_in,
  input  wire logic [3:0]  cfg_byte_en_b_in,
  input  wire logic        cfg_wr_en_b_in,
  input  wire logic        cfg_rd_en_b_in,
  output logic      [31:0] cfg_do_out,
  output logic             cfg_rd_wr_done_b_out
);

  // ********************************************************
  // Address decode
  // ********************************************************
  function automatic logic [9:0] dword_of(input logic [11:0] byte_addr);
    dword_of = byte_addr[11:2];
  endfunction

  function automatic logic [15:0] lane_mask(input logic [1:0] be_b);
    lane_mask = {{8{~be_b[1]}}, {8{~be_b[0]}}};
  endfunction

  port_state_e state_q;
  port_state_e state_d;
  logic        req;
  logic        take;
  logic        wr_take;
  logic        hit_status;
  logic        hit_sec;
  logic        rp_mode;
  logic        ep_mode;
  logic        par_resp_en;
  logic        serr_en;
  logic        user_abort;
  logic [15:0] wr_ones;
  logic [15:0] st_set;
  logic [15:0] st_clr;
  logic [15:0] sec_set;
  logic [15:0] sec_clr;
  logic [15:0] st_bits;
  logic [15:0] sec_bits;
  logic [15:0] status_word;
  logic [15:0] sec_word;
  logic        intr_q;

  assign rp_mode     = root_port_mode_in;
  assign ep_mode     = ~root_port_mode_in;
  assign par_resp_en = command_word_in[CMD_PER_BIT];
  assign serr_en     = command_word_in[CMD_SERR_BIT];
  assign user_abort  = ~user_cpl_abort_b_in;

  assign req        = ~cfg_wr_en_b_in | ~cfg_rd_en_b_in;
  assign take       = (state_q == PORT_IDLE) && req;
  assign wr_take    = take && !cfg_wr_en_b_in;
  assign hit_status = (cfg_dwaddr_in == dword_of(STATUS_OFFSET));
  assign hit_sec    = (cfg_dwaddr_in == dword_of(SEC_STATUS_OFFSET));
  assign wr_ones    = cfg_di_in[31:HALF_WORD_LSB] & lane_mask(cfg_byte_en_b_in[3:2]);

  // ********************************************************
  // Status set conditions
  // ********************************************************
  always_comb begin
    st_set = 16'h0000;
    if (ep_mode) begin
      st_set[PARITY_ERR_BIT] = par_resp_en & (rx_poisoned_cpl_in | tx_poisoned_wr_in);
      st_set[SIG_ABORT_BIT]  = user_abort;
      st_set[RCV_ABORT_BIT]  = rx_cpl_abort_in;
      st_set[RCV_UR_BIT]     = rx_cpl_unsupported_in;
      st_set[SYS_ERR_BIT]    = serr_en & tx_err_msg_in;
      st_set[DET_PARITY_BIT] = rx_poisoned_tlp_in;
    end else begin
      // Abort and master-abort bits stay unset here
      st_set[PARITY_ERR_BIT] = par_resp_en & rx_poisoned_cpl_in;
      st_set[SYS_ERR_BIT]    = serr_en & ((secondary_system_error_report_enable_in & rx_err_msg_in)
                                          | msg_upstream_err_in);
      st_set[DET_PARITY_BIT] = tx_poisoned_tlp_in;
    end
    st_set = st_set & STATUS_W1C_MASK;
  end

  // ********************************************************
  // Secondary status set conditions
  // ********************************************************
  always_comb begin
    sec_set = 16'h0000;
    if (rp_mode) begin
      sec_set[PARITY_ERR_BIT] = secondary_parity_resp_en_in
                                & (rx_poisoned_cpl_in | tx_poisoned_wr_in);
      sec_set[SIG_ABORT_BIT]  = user_abort;
      sec_set[RCV_ABORT_BIT]  = rx_cpl_abort_in;
      sec_set[RCV_UR_BIT]     = rx_cpl_unsupported_in;
      sec_set[SYS_ERR_BIT]    = rx_err_msg_in;
    end
    sec_set = sec_set & SEC_W1C_MASK;
  end

  // Clears come only from a write of ones into enabled byte lanes
  assign st_clr  = (wr_take && hit_status) ? (wr_ones & STATUS_W1C_MASK) : 16'h0000;
  assign sec_clr = (wr_take && hit_sec && rp_mode) ? (wr_ones & SEC_W1C_MASK) : 16'h0000;

  w1c_bit_bank #(
    .WIDTH     (16),
    .RESET_VAL (STATUS_RESET)
  ) u_status_bits (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .set_in      (st_set),
    .clr_in      (st_clr),
    .bits_out    (st_bits)
  );

  w1c_bit_bank #(
    .WIDTH     (16),
    .RESET_VAL (SEC_STATUS_RESET)
  ) u_sec_bits (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .set_in      (sec_set),
    .clr_in      (sec_clr),
    .bits_out    (sec_bits)
  );

  // ********************************************************
  // Interrupt status, read-only
  // ********************************************************
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      intr_q <= INTR_RESET;
    end else if (rp_mode) begin
      intr_q <= 1'b0;
    end else if (intx_set_in) begin
      intr_q <= 1'b1;
    end else if (intx_clear_in) begin
      intr_q <= 1'b0;
    end
  end

  always_comb begin
    status_word                  = st_bits & STATUS_W1C_MASK;
    status_word[INTR_STATUS_BIT] = intr_q;
    status_word[CAP_LIST_BIT]    = 1'b1;
    sec_word                     = rp_mode ? (sec_bits & SEC_W1C_MASK) : 16'h0000;
  end

  // ********************************************************
  // Configuration port handshake
  // ********************************************************
  // Each access is answered once; the port then waits for the
  // strobes to drop so a held strobe is not taken twice.
  always_comb begin
    state_d = state_q;
    case (state_q)
      PORT_IDLE: begin
        if (req) begin
          state_d = PORT_ACK;
        end
      end
      PORT_ACK: begin
        state_d = req ? PORT_WAIT : PORT_IDLE;
      end
      PORT_WAIT: begin
        if (!req) begin
          state_d = PORT_IDLE;
        end
      end
      default: begin
        state_d = PORT_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      state_q <= PORT_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      cfg_rd_wr_done_b_out <= 1'b1;
    end else begin
      cfg_rd_wr_done_b_out <= ~take;
    end
  end

  // Other addresses of the space live elsewhere and read as zero here
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      cfg_do_out <= 32'h0000_0000;
    end else if (take && !cfg_rd_en_b_in) begin
      if (hit_status) begin
        cfg_do_out <= {status_word, 16'h0000};
      end else if (hit_sec) begin
        cfg_do_out <= {sec_word, 16'h0000};
      end else begin
        cfg_do_out <= 32'h0000_0000;
      end
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  property p_fixed_bits;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      status_word[2:0] == 3'b000 && status_word[7:5] == 3'b000 && status_word[10:9] == 2'b00
      && status_word[CAP_LIST_BIT] && sec_word[7:0] == 8'h00 && sec_word[10:9] == 2'b00;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("Fixed status bits wrong");

  property p_intr_set;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      ep_mode && intx_set_in |=> status_word[INTR_STATUS_BIT];
  endproperty
  a_intr_set: assert property (p_intr_set) else $error("Interrupt status not set");

  property p_ep_parity;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      ep_mode && par_resp_en && tx_poisoned_wr_in |=> status_word[PARITY_ERR_BIT];
  endproperty
  a_ep_parity: assert property (p_ep_parity) else $error("Parity bit not set on poisoned write");

  property p_ep_rcv_abort;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      ep_mode && rx_cpl_abort_in |=> status_word[RCV_ABORT_BIT];
  endproperty
  a_ep_rcv_abort: assert property (p_ep_rcv_abort) else $error("Received abort not set");

  property p_rp_never;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      rp_mode && $stable(rp_mode) |=> status_word[13:11] == $past(status_word[13:11]) && !$rose(status_word[13]);
  endproperty
  a_rp_never: assert property (p_rp_never) else $error("Root port set an abort bit");

  property p_rp_intr;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      rp_mode ##1 rp_mode |-> !status_word[INTR_STATUS_BIT];
  endproperty
  a_rp_intr: assert property (p_rp_intr) else $error("Root port interrupt status active");

  property p_w1c_clear;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      wr_take && hit_status && wr_ones[DET_PARITY_BIT] && !st_set[DET_PARITY_BIT]
      |=> !status_word[DET_PARITY_BIT];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("Write of one did not clear");

  property p_w1c_hold;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      status_word[SYS_ERR_BIT] && !st_clr[SYS_ERR_BIT] |=> status_word[SYS_ERR_BIT];
  endproperty
  a_w1c_hold: assert property (p_w1c_hold) else $error("Sticky bit lost without a clear");

  property p_sec_sys_err;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      rp_mode && rx_err_msg_in ##1 rp_mode |-> sec_word[SYS_ERR_BIT];
  endproperty
  a_sec_sys_err: assert property (p_sec_sys_err) else $error("Secondary system error not set");

  property p_done_pulse;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      take |=> !cfg_rd_wr_done_b_out ##1 cfg_rd_wr_done_b_out;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("Done pulse not one cycle");

endmodule

// File: tb/far_side_model.sv
// Far-side model: link traffic and user application event pulses
`timescale 1ns/1ps
module far_side_model (
  // Clock
  input  wire logic        core_clk_in,
  // Requested events, held as levels by the bench
  input  wire logic [11:0] ev_req_in,
  // Event pulses, one bit per event input of the block
  output logic      [11:0] ev_out,
  // User completer-abort report, active low
  output logic             user_cpl_abort_b_out
);
  logic [11:0] req_seen_q;

  // Each newly raised request bit becomes one pulse, launched off the falling
  // edge so that it spans exactly one rising edge of the block
  always @(negedge core_clk_in) begin
    ev_out     <= ev_req_in & ~req_seen_q;
    req_seen_q <= ev_req_in;
  end

  // The abort report idles high; a low cycle is one report
  assign user_cpl_abort_b_out = ~ev_out[9];
endmodule

// File: tb/testbench.sv
// Self-checking bench for the status and error logging block
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin num_errors++; $display("wrong value at %0t: %s", $time, msg); end end
module testbench;
  logic        core_clk_in = 1'b0;
  logic        rst_b       = 1'b0;
  logic        mode        = 1'b0;
  logic [15:0] cmd         = 16'h0000;
  logic        sec_per     = 1'b0;
  logic        sec_serr    = 1'b0;
  logic [9:0]  dwaddr      = 10'h000;
  logic [31:0] di          = 32'h0000_0000;
  logic [3:0]  be_b        = 4'hf;
  logic        wr_b        = 1'b1;
  logic        rd_b        = 1'b1;
  logic [11:0] ev_req      = 12'h000;
  wire  [11:0] ev;
  wire         abort_b;
  wire  [31:0] do_w;
  wire         done_b;
  int          num_errors  = 0;
  int          checks      = 0;
  int          cycles      = 0;

  // Event bits: 0 rx poisoned cpl, 1 rx poisoned, 2 rx abort cpl, 3 rx unsupported cpl,
  // 4 rx err msg, 5 tx poisoned wr, 6 tx poisoned, 7 tx err msg, 8 upstream err,
  // 9 user abort, 10 intx set, 11 intx clear
  far_side_model peer (.core_clk_in(core_clk_in), .ev_req_in(ev_req), .ev_out(ev), .user_cpl_abort_b_out(abort_b));

  status_err_log dut (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b), .root_port_mode_in(mode), .command_word_in(cmd),
    .secondary_parity_resp_en_in(sec_per), .secondary_system_error_report_enable_in(sec_serr),
    .rx_poisoned_cpl_in(ev[0]), .rx_poisoned_tlp_in(ev[1]), .rx_cpl_abort_in(ev[2]),
    .rx_cpl_unsupported_in(ev[3]), .rx_err_msg_in(ev[4]), .tx_poisoned_wr_in(ev[5]),
    .tx_poisoned_tlp_in(ev[6]), .tx_err_msg_in(ev[7]), .msg_upstream_err_in(ev[8]),
    .user_cpl_abort_b_in(abort_b), .intx_set_in(ev[10]), .intx_clear_in(ev[11]),
    .cfg_dwaddr_in(dwaddr), .cfg_di_in(di), .cfg_byte_en_b_in(be_b), .cfg_wr_en_b_in(wr_b),
    .cfg_rd_en_b_in(rd_b), .cfg_do_out(do_w), .cfg_rd_wr_done_b_out(done_b)
  );

  initial begin
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  // A hang is cut short well beyond the roughly 130 cycles the tests need
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ******************************************************
  // Configuration port access
  // ******************************************************
  task automatic xfer(input logic wr, input logic [9:0] dw, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
    int n;
    @(negedge core_clk_in);
    dwaddr = dw;
    di = d;
    be_b = be;
    wr_b = ~wr;
    rd_b = wr;
    n = 0;
    do begin
      @(negedge core_clk_in);
      n++;
    end while (done_b !== 1'b0 && n < 8);
    `CHK(done_b, 1'b0, "no done pulse")
    q = do_w;
    wr_b = 1'b1;
    rd_b = 1'b1;
    be_b = 4'hf;
  endtask

  task automatic chk_rd(input logic [9:0] dw, input logic [15:0] e);
    logic [31:0] q;
    xfer(1'b0, dw, 32'h0000_0000, 4'hf, q);
    `CHK(q, {e, 16'h0000}, "read data")
  endtask

  task automatic wr_hi(input logic [15:0] d, input logic [3:0] be);
    logic [31:0] q;
    xfer(1'b1, 10'h001, {d, 16'h0000}, be, q);
  endtask

  task automatic do_reset(input logic rp);
    @(negedge core_clk_in);
    rst_b = 1'b0;
    mode = rp;
    cmd = 16'h0000;
    sec_per = 1'b0;
    sec_serr = 1'b0;
    repeat (10) @(negedge core_clk_in);
    rst_b = 1'b1;
  endtask

  // Requests go in by non-blocking assignment so the model samples them one
  // falling edge later without a race; the pulse stands over the next rising edge
  task automatic fire(input logic [11:0] m);
    @(negedge core_clk_in);
    ev_req <= m;
    @(negedge core_clk_in);
    ev_req <= 12'h000;
  endtask

  // ******************************************************
  // Scenarios
  // ******************************************************
  task automatic test_fixed_bits;
    do_reset(1'b0);
    chk_rd(10'h001, 16'h0010);
    chk_rd(10'h007, 16'h0000);
    chk_rd(10'h002, 16'h0000);
  endtask

  task automatic test_ep_events;
    fire(12'h001);
    fire(12'h002);
    chk_rd(10'h001, 16'h8010);
    cmd = 16'h0040;
    fire(12'h020);
    chk_rd(10'h001, 16'h8110);
    fire(12'h20c);
    chk_rd(10'h001, 16'hb910);
    fire(12'h080);
    chk_rd(10'h001, 16'hb910);
    cmd = 16'h0140;
    fire(12'h080);
    chk_rd(10'h001, 16'hf910);
    fire(12'h400);
    chk_rd(10'h001, 16'hf918);
    fire(12'h800);
    chk_rd(10'h001, 16'hf910);
  endtask

  task automatic test_w1c;
    wr_hi(16'h8000, 4'b0011);
    chk_rd(10'h001, 16'h7910);
    wr_hi(16'h0000, 4'b0000);
    chk_rd(10'h001, 16'h7910);
    wr_hi(16'hffff, 4'b0011);
    chk_rd(10'h001, 16'h0010);
    fire(12'h001);
    chk_rd(10'h001, 16'h0110);
    // Upper lane masked off: the ones must not reach bits 15:8
    wr_hi(16'hffff, 4'b1000);
    chk_rd(10'h001, 16'h0110);
    // Poisoned packet pulse lands on the same edge that takes the clearing write
    @(negedge core_clk_in);
    ev_req <= 12'h002;
    wr_hi(16'h8000, 4'b0011);
    ev_req <= 12'h000;
    chk_rd(10'h001, 16'h8110);
  endtask

  task automatic test_rp_events;
    do_reset(1'b1);
    fire(12'h400);
    fire(12'h20c);
    chk_rd(10'h001, 16'h0010);
    chk_rd(10'h007, 16'h3800);
    cmd = 16'h0100;
    fire(12'h010);
    chk_rd(10'h001, 16'h0010);
    chk_rd(10'h007, 16'h7800);
    fire(12'h100);
    chk_rd(10'h001, 16'h4010);
    wr_hi(16'h4000, 4'b0011);
    sec_serr = 1'b1;
    fire(12'h010);
    chk_rd(10'h001, 16'h4010);
    fire(12'h040);
    chk_rd(10'h001, 16'hc010);
  endtask

  task automatic test_rp_parity;
    logic [31:0] q;
    cmd = 16'h0140;
    fire(12'h020);
    chk_rd(10'h001, 16'hc010);
    fire(12'h001);
    chk_rd(10'h001, 16'hc110);
    chk_rd(10'h007, 16'h7800);
    sec_per = 1'b1;
    fire(12'h020);
    chk_rd(10'h007, 16'h7900);
    xfer(1'b1, 10'h007, 32'h4100_0000, 4'b0011, q);
    chk_rd(10'h007, 16'h3800);
    fire(12'h001);
    chk_rd(10'h007, 16'h3900);
  endtask

  initial begin
    test_fixed_bits();
    test_ep_events();
    test_w1c();
    test_rp_events();
    test_rp_parity();
    print_verdict();
  end
endmodule
